// ### rtl/cup_pkg.sv
/*
  Package of the configurable serial port: register offsets, field positions,
  reset values, encodings and timing counts.
  Assumes a 50 MHz system clock and an APB bus with 8-bit byte addresses.
*/
package cup_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_DEFAULT = 115200;
  localparam int BAUD_MIN = 300;
  localparam int BAUD_MAX = 3_000_000;
  localparam int DIV_W = 18;
  // Clock cycles per bit; rounds down, so the highest rate never runs slow
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [DIV_W-1:0] DIV_LONGEST = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_SHORTEST = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam int FIFO_AW = 8;
  localparam int FIFO_W = 10;

  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CFG_STORE = 8'h08;
  localparam logic [7:0] ADDR_DIV_STORE = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_INT_STAT = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;
  localparam logic [7:0] ADDR_CFG_ACTIVE = 8'h1C;
  localparam logic [7:0] ADDR_DIV_ACTIVE = 8'h20;

  localparam int CFG_W = 15;
  localparam int CFG_PINS = 0;
  localparam int CFG_SEVEN = 2;
  localparam int CFG_STOP2 = 3;
  localparam int CFG_PAR = 4;
  localparam int CFG_INV_RTS = 7;
  localparam int CFG_INV_CTS = 8;
  localparam int CFG_INV_DTR = 9;
  localparam int CFG_INV_DSR = 10;
  localparam int CFG_INV_DCD = 11;
  localparam int CFG_INV_RI = 12;
  localparam int CFG_DROP = 13;
  localparam int CFG_SUSP_PU_OFF = 14;
  localparam logic [CFG_W-1:0] CFG_RESET = 15'h4003;

  localparam int INT_W = 6;
  localparam int INT_RX = 0;
  localparam int INT_TX_EMPTY = 1;
  localparam int INT_PARITY = 2;
  localparam int INT_FRAMING = 3;
  localparam int INT_OVERRUN = 4;
  localparam int INT_MODEM = 5;

  typedef enum logic [1:0] {
    CUP_PINS_2 = 2'b00,
    CUP_PINS_4 = 2'b01,
    CUP_PINS_6 = 2'b10,
    CUP_PINS_8 = 2'b11
  } cup_pins_e;

  typedef enum logic [2:0] {
    CUP_PAR_NONE = 3'b000,
    CUP_PAR_ODD = 3'b001,
    CUP_PAR_EVEN = 3'b010,
    CUP_PAR_MARK = 3'b011,
    CUP_PAR_SPACE = 3'b100
  } cup_par_e;
endpackage

// ### rtl/cup_mem.sv
/*
  Simple dual-port memory with registered read data, one per buffer.
  Assumes one clock and that the caller keeps the addresses in range.
*/
`timescale 1ns/1ns
`default_nettype none
module cup_mem #(
  parameter int W = 10,
  parameter int AW = 8
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rd_data <= '0;
    end
    else if (i_rd_en)
    begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule
`default_nettype wire

// ### rtl/cup_port.sv
/*
  Configurable asynchronous serial port with modem lines, APB registers,
  two 256-entry buffers and one level interrupt.
  Assumes pin inputs synchronous to i_clock and an APB master.
*/
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module cup_port #(
  parameter int AW = cup_pkg::FIFO_AW
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_reinit,
  input wire logic i_suspend,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_rts_n,
  input wire logic i_cts_n,
  output logic o_dtr_n,
  input wire logic i_dsr_n,
  input wire logic i_ri_n,
  input wire logic i_dcd_n,
  output logic o_cts_pullup_en,
  output logic o_dsr_pullup_en,
  output logic o_irq
);
  localparam int DW = cup_pkg::DIV_W;
  localparam int CW = cup_pkg::CFG_W;
  localparam int IW = cup_pkg::INT_W;

  typedef enum logic [2:0] {
    CUP_TX_IDLE = 3'b000, CUP_TX_FETCH = 3'b001, CUP_TX_START = 3'b010,
    CUP_TX_DATA = 3'b011, CUP_TX_PAR = 3'b100, CUP_TX_STOP = 3'b101
  } cup_tx_e;
  typedef enum logic [2:0] {
    CUP_RX_IDLE = 3'b000, CUP_RX_START = 3'b001, CUP_RX_DATA = 3'b010,
    CUP_RX_PAR = 3'b011, CUP_RX_STOP = 3'b100
  } cup_rx_e;

  function automatic logic par_bit(input logic [7:0] d, input logic seven, input logic [2:0] mode);
    logic x;
    x = ^(seven ? (d & 8'h7F) : d);
    case (mode)
      cup_pkg::CUP_PAR_ODD: par_bit = ~x;
      cup_pkg::CUP_PAR_EVEN: par_bit = x;
      cup_pkg::CUP_PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cup_pkg::ADDR_DATA) || (a == cup_pkg::ADDR_STATUS) || (a == cup_pkg::ADDR_CFG_STORE) ||
      (a == cup_pkg::ADDR_DIV_STORE) || (a == cup_pkg::ADDR_CTRL) || (a == cup_pkg::ADDR_INT_STAT) ||
      (a == cup_pkg::ADDR_INT_MASK) || (a == cup_pkg::ADDR_CFG_ACTIVE) || (a == cup_pkg::ADDR_DIV_ACTIVE);
  endfunction

  // Stored settings (software view) and active settings (what the port runs on)
  logic [CW-1:0] cfg_st_q, cfg_st_d, cfg_q, cfg_d;
  logic [DW-1:0] div_st_q, div_st_d, div_q, div_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [IW-1:0] ist_q, ist_d, imask_q, imask_d, ev;
  logic [31:0] prdata_q, prdata_d;
  logic rdsel_q, rdsel_d;
  logic [3:0] sense_q;
  logic sense_ok_q;
  logic [AW:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d, rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [cup_pkg::FIFO_W-1:0] tx_rd_data, rx_rd_data;
  logic tx_full, tx_empty, rx_full, rx_empty, tx_rd, rx_rd, rx_push, tx_push;
  logic setup, acc, wr_acc;
  logic seven, stop2, use_hs, use_dsr, use_ri;
  logic [2:0] par;
  logic cts_a, dsr_a, dcd_a, ri_a, rts_a, dtr_a;

  cup_tx_e tx_st_q, tx_st_d;
  logic [DW-1:0] tx_cnt_q, tx_cnt_d;
  logic [2:0] tx_bit_q, tx_bit_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic tx_pb_q, tx_pb_d, txd_q, txd_d, tx_done;
  cup_rx_e rx_st_q, rx_st_d;
  logic [DW-1:0] rx_cnt_q, rx_cnt_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_byte;
  logic rx_pb_q, rx_pb_d, rxd_q, rx_done, rx_perr, rx_ferr;

  assign seven = cfg_q[cup_pkg::CFG_SEVEN];
  assign stop2 = cfg_q[cup_pkg::CFG_STOP2];
  assign par = cfg_q[cup_pkg::CFG_PAR +: 3];
  assign use_hs = cfg_q[cup_pkg::CFG_PINS +: 2] != cup_pkg::CUP_PINS_2;
  assign use_dsr = cfg_q[cup_pkg::CFG_PINS + 1];
  assign use_ri = cfg_q[cup_pkg::CFG_PINS +: 2] == cup_pkg::CUP_PINS_8;

  // Unused inputs read as deasserted, except CTS which then never blocks sending
  assign cts_a = use_hs ? (~i_cts_n ^ cfg_q[cup_pkg::CFG_INV_CTS]) : 1'b1;
  assign dsr_a = use_dsr & (~i_dsr_n ^ cfg_q[cup_pkg::CFG_INV_DSR]);
  assign dcd_a = use_ri & (~i_dcd_n ^ cfg_q[cup_pkg::CFG_INV_DCD]);
  assign ri_a = use_ri & (~i_ri_n ^ cfg_q[cup_pkg::CFG_INV_RI]);
  // RTS drops while the receive buffer is full so the far end holds off
  assign rts_a = ctrl_q[0] & ~rx_full;
  assign dtr_a = ctrl_q[1];
  assign o_rts_n = use_hs ? ~(rts_a ^ cfg_q[cup_pkg::CFG_INV_RTS]) : 1'b1;
  assign o_dtr_n = use_dsr ? ~(dtr_a ^ cfg_q[cup_pkg::CFG_INV_DTR]) : 1'b1;
  assign o_cts_pullup_en = ~(i_suspend & cfg_q[cup_pkg::CFG_SUSP_PU_OFF]);
  assign o_dsr_pullup_en = ~(i_suspend & cfg_q[cup_pkg::CFG_SUSP_PU_OFF]);
  assign o_txd = txd_q;
  assign o_irq = |(ist_q & imask_q);

  assign tx_full = (tx_wp_q - tx_rp_q) == (AW + 1)'(1 << AW);
  assign tx_empty = tx_wp_q == tx_rp_q;
  assign rx_full = (rx_wp_q - rx_rp_q) == (AW + 1)'(1 << AW);
  assign rx_empty = rx_wp_q == rx_rp_q;

  assign setup = i_psel & ~i_penable;
  assign acc = i_psel & i_penable;
  assign wr_acc = acc & i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = acc & (~mapped(i_paddr) | (i_pwrite & i_paddr == cup_pkg::ADDR_DATA & tx_full));
  assign o_prdata = rdsel_q ? {22'h00_0000, rx_rd_data} : prdata_q;
  assign tx_push = wr_acc & i_paddr == cup_pkg::ADDR_DATA & ~tx_full;
  // Buffer read issued in the setup phase so the byte is there for the access phase
  assign rx_rd = setup & ~i_pwrite & i_paddr == cup_pkg::ADDR_DATA & ~rx_empty;

  cup_mem #(.W(cup_pkg::FIFO_W), .AW(AW)) u_tx_mem (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_wr_en(tx_push), .i_wr_addr(tx_wp_q[AW-1:0]),
    .i_wr_data({2'b00, i_pwdata[7:0]}), .i_rd_en(tx_rd), .i_rd_addr(tx_rp_q[AW-1:0]), .o_rd_data(tx_rd_data)
  );
  cup_mem #(.W(cup_pkg::FIFO_W), .AW(AW)) u_rx_mem (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_wr_en(rx_push), .i_wr_addr(rx_wp_q[AW-1:0]),
    .i_wr_data({rx_ferr, rx_perr, rx_byte}), .i_rd_en(rx_rd), .i_rd_addr(rx_rp_q[AW-1:0]),
    .o_rd_data(rx_rd_data)
  );

  // Registers and buffer pointers
  always_comb
  begin
    cfg_st_d = cfg_st_q;
    div_st_d = div_st_q;
    cfg_d = cfg_q;
    div_d = div_q;
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    ist_d = ist_q;
    prdata_d = prdata_q;
    rdsel_d = 1'b0;
    tx_wp_d = tx_wp_q + (AW + 1)'(tx_push);
    tx_rp_d = tx_rp_q + (AW + 1)'(tx_st_q == CUP_TX_FETCH);
    rx_wp_d = rx_wp_q + (AW + 1)'(rx_push);
    rx_rp_d = rx_rp_q + (AW + 1)'(acc & rdsel_q);
    if (setup)
    begin
      rdsel_d = rx_rd;
      if (i_paddr == cup_pkg::ADDR_STATUS)
        prdata_d = {23'h00_0000, tx_st_q != CUP_TX_IDLE, ri_a, dcd_a, dsr_a, cts_a,
          rx_empty, rx_full, tx_empty, tx_full};
      else if (i_paddr == cup_pkg::ADDR_CFG_STORE)
        prdata_d = {17'h0_0000, cfg_st_q};
      else if (i_paddr == cup_pkg::ADDR_DIV_STORE)
        prdata_d = {14'h0000, div_st_q};
      else if (i_paddr == cup_pkg::ADDR_CTRL)
        prdata_d = {30'h0000_0000, ctrl_q};
      else if (i_paddr == cup_pkg::ADDR_INT_STAT)
        prdata_d = {26'h000_0000, ist_q};
      else if (i_paddr == cup_pkg::ADDR_INT_MASK)
        prdata_d = {26'h000_0000, imask_q};
      else if (i_paddr == cup_pkg::ADDR_CFG_ACTIVE)
        prdata_d = {17'h0_0000, cfg_q};
      else if (i_paddr == cup_pkg::ADDR_DIV_ACTIVE)
        prdata_d = {14'h0000, div_q};
      else
        prdata_d = 32'h0000_0000;
    end
    if (wr_acc)
    begin
      if (i_paddr == cup_pkg::ADDR_CFG_STORE)
        cfg_st_d = i_pwdata[CW-1:0];
      else if (i_paddr == cup_pkg::ADDR_DIV_STORE)
        div_st_d = (i_pwdata[DW-1:0] == '0) ? DW'(1) : i_pwdata[DW-1:0];
      else if (i_paddr == cup_pkg::ADDR_CTRL)
        ctrl_d = i_pwdata[1:0];
      else if (i_paddr == cup_pkg::ADDR_INT_MASK)
        imask_d = i_pwdata[IW-1:0];
    end
    // Clear first, then set, so an event in the clearing cycle survives
    if (wr_acc && i_paddr == cup_pkg::ADDR_INT_STAT)
      ist_d = ist_d & ~i_pwdata[IW-1:0];
    ist_d = ist_d | ev;
    if (i_reinit)
    begin
      cfg_d = cfg_st_q;
      div_d = div_st_q;
      tx_wp_d = '0;
      tx_rp_d = '0;
      rx_wp_d = '0;
      rx_rp_d = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_st_q <= cup_pkg::CFG_RESET;
      div_st_q <= cup_pkg::DIV_DEFAULT;
      cfg_q <= cup_pkg::CFG_RESET;
      div_q <= cup_pkg::DIV_DEFAULT;
      ctrl_q <= 2'b00;
      ist_q <= '0;
      imask_q <= '0;
      prdata_q <= 32'h0000_0000;
      rdsel_q <= 1'b0;
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      sense_q <= 4'h0;
      sense_ok_q <= 1'b0;
    end
    else
    begin
      cfg_st_q <= cfg_st_d;
      div_st_q <= div_st_d;
      cfg_q <= cfg_d;
      div_q <= div_d;
      ctrl_q <= ctrl_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      prdata_q <= prdata_d;
      rdsel_q <= rdsel_d;
      tx_wp_q <= tx_wp_d;
      tx_rp_q <= tx_rp_d;
      rx_wp_q <= rx_wp_d;
      rx_rp_q <= rx_rp_d;
      sense_q <= {ri_a, dcd_a, dsr_a, cts_a};
      sense_ok_q <= ~i_reinit;
    end
  end

  // Transmitter; CTS is looked at only between characters
  assign tx_done = tx_cnt_q == div_q - DW'(1);
  assign tx_rd = (tx_st_q == CUP_TX_IDLE) & ~tx_empty & cts_a & ~i_reinit;
  always_comb
  begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_done ? '0 : tx_cnt_q + DW'(1);
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_pb_d = tx_pb_q;
    txd_d = txd_q;
    case (tx_st_q)
      CUP_TX_IDLE:
      begin
        txd_d = 1'b1;
        tx_cnt_d = '0;
        if (tx_rd)
          tx_st_d = CUP_TX_FETCH;
      end
      CUP_TX_FETCH:
      begin
        tx_sh_d = tx_rd_data[7:0];
        tx_pb_d = par_bit(tx_rd_data[7:0], seven, par);
        tx_cnt_d = '0;
        tx_bit_d = 3'd0;
        txd_d = 1'b0;
        tx_st_d = CUP_TX_START;
      end
      CUP_TX_START:
        if (tx_done)
        begin
          txd_d = tx_sh_q[0];
          tx_st_d = CUP_TX_DATA;
        end
      CUP_TX_DATA:
        if (tx_done)
        begin
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_bit_d = tx_bit_q + 3'd1;
          txd_d = tx_sh_q[1];
          if (tx_bit_q == (seven ? 3'd6 : 3'd7))
          begin
            tx_bit_d = 3'd0;
            txd_d = (par == cup_pkg::CUP_PAR_NONE) ? 1'b1 : tx_pb_q;
            tx_st_d = (par == cup_pkg::CUP_PAR_NONE) ? CUP_TX_STOP : CUP_TX_PAR;
          end
        end
      CUP_TX_PAR:
        if (tx_done)
        begin
          txd_d = 1'b1;
          tx_st_d = CUP_TX_STOP;
        end
      CUP_TX_STOP:
        if (tx_done)
        begin
          if (stop2 && tx_bit_q == 3'd0)
            tx_bit_d = 3'd1;
          else
            tx_st_d = CUP_TX_IDLE;
        end
      default:
        tx_st_d = CUP_TX_IDLE;
    endcase
    if (i_reinit)
    begin
      tx_st_d = CUP_TX_IDLE;
      txd_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_st_q <= CUP_TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= 3'd0;
      tx_sh_q <= 8'h00;
      tx_pb_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else
    begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_pb_q <= tx_pb_d;
      txd_q <= txd_d;
    end
  end

  // Receiver samples each bit at its middle, timed from the start edge
  assign rx_done = rx_cnt_q == ((rx_st_q == CUP_RX_START) ? (div_q >> 1) : div_q - DW'(1));
  assign rx_byte = seven ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;
  assign rx_perr = (par != cup_pkg::CUP_PAR_NONE) & (rx_pb_q != par_bit(rx_byte, seven, par));
  assign rx_ferr = ~i_rxd;
  // Overrun loses the new byte; the buffered ones stay intact
  assign rx_push = (rx_st_q == CUP_RX_STOP) & rx_done & ~rx_full & ~i_reinit &
    ~(cfg_q[cup_pkg::CFG_DROP] & (rx_perr | rx_ferr));
  assign ev[cup_pkg::INT_RX] = rx_push;
  assign ev[cup_pkg::INT_TX_EMPTY] = (tx_st_q == CUP_TX_STOP) & (tx_st_d == CUP_TX_IDLE) & tx_empty;
  assign ev[cup_pkg::INT_PARITY] = (rx_st_q == CUP_RX_STOP) & rx_done & rx_perr;
  assign ev[cup_pkg::INT_FRAMING] = (rx_st_q == CUP_RX_STOP) & rx_done & rx_ferr;
  assign ev[cup_pkg::INT_OVERRUN] = (rx_st_q == CUP_RX_STOP) & rx_done & rx_full;
  // Skipped after reset and reload, when the sensed set changes with no pin moving
  assign ev[cup_pkg::INT_MODEM] = sense_ok_q & (sense_q != {ri_a, dcd_a, dsr_a, cts_a});

  always_comb
  begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_done ? '0 : rx_cnt_q + DW'(1);
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_pb_d = rx_pb_q;
    case (rx_st_q)
      CUP_RX_IDLE:
      begin
        rx_cnt_d = '0;
        if (rxd_q && !i_rxd)
          rx_st_d = CUP_RX_START;
      end
      CUP_RX_START:
        if (rx_done)
        begin
          rx_bit_d = 3'd0;
          rx_st_d = i_rxd ? CUP_RX_IDLE : CUP_RX_DATA;
        end
      CUP_RX_DATA:
        if (rx_done)
        begin
          rx_sh_d = {i_rxd, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'd1;
          if (rx_bit_q == (seven ? 3'd6 : 3'd7))
            rx_st_d = (par == cup_pkg::CUP_PAR_NONE) ? CUP_RX_STOP : CUP_RX_PAR;
        end
      CUP_RX_PAR:
        if (rx_done)
        begin
          rx_pb_d = i_rxd;
          rx_st_d = CUP_RX_STOP;
        end
      CUP_RX_STOP:
        if (rx_done)
          rx_st_d = CUP_RX_IDLE;
      default:
        rx_st_d = CUP_RX_IDLE;
    endcase
    if (i_reinit)
      rx_st_d = CUP_RX_IDLE;
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rx_st_q <= CUP_RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 3'd0;
      rx_sh_q <= 8'h00;
      rx_pb_q <= 1'b0;
      rxd_q <= 1'b1;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_pb_q <= rx_pb_d;
      rxd_q <= i_rxd;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  property p_idle_high;
    tx_st_q == CUP_TX_IDLE && $past(tx_st_q) == CUP_TX_IDLE |-> o_txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  property p_start_low;
    tx_st_q == CUP_TX_FETCH |=> tx_st_q == CUP_TX_START && !o_txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_two_pin;
    cfg_q[1:0] == cup_pkg::CUP_PINS_2 |-> o_rts_n && o_dtr_n && cts_a;
  endproperty
  a_two_pin: assert property (p_two_pin) else $error("handshake used in two-pin type");
  property p_no_dtr;
    !cfg_q[1] |-> o_dtr_n && !dsr_a && !ri_a && !dcd_a;
  endproperty
  a_no_dtr: assert property (p_no_dtr) else $error("six-pin lines used in smaller type");
  property p_cfg_frozen;
    !$stable(cfg_q) || !$stable(div_q) |-> $past(i_reinit);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("settings changed without reinit");
  property p_suspend_pu;
    i_suspend && cfg_q[cup_pkg::CFG_SUSP_PU_OFF] |-> !o_cts_pullup_en && !o_dsr_pullup_en;
  endproperty
  a_suspend_pu: assert property (p_suspend_pu) else $error("pull-up on in suspend");
  property p_drop;
    rx_st_q == CUP_RX_STOP && rx_done && cfg_q[cup_pkg::CFG_DROP] && (rx_perr || rx_ferr) |=> $stable(rx_wp_q);
  endproperty
  a_drop: assert property (p_drop) else $error("erroneous byte stored");
  property p_overrun;
    rx_st_q == CUP_RX_STOP && rx_done && rx_full |=> ist_q[cup_pkg::INT_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_depth;
    (tx_wp_q - tx_rp_q) <= (AW + 1)'(1 << AW) && (rx_wp_q - rx_rp_q) <= (AW + 1)'(1 << AW);
  endproperty
  a_depth: assert property (p_depth) else $error("buffer above its depth");
  property p_width;
    tx_st_q == CUP_TX_DATA |-> tx_bit_q <= (seven ? 3'd6 : 3'd7);
  endproperty
  a_width: assert property (p_width) else $error("too many data bits");
  c_tx_par: cover property (tx_st_q == CUP_TX_PAR ##1 tx_st_q == CUP_TX_STOP);
  c_rx_push: cover property (rx_push);
  c_irq: cover property ($rose(o_irq));
endmodule
`default_nettype wire

// ### bench/cup_dev.sv
/* Serial device model on the port's data lines.
   Assumes DIV clocks per bit and the frame length after the start bit on i_nbits. */
`timescale 1ns/1ns
`default_nettype none
module cup_dev #(parameter int DIV = 8) (
  input wire logic i_clock,
  input wire logic i_txd,
  input wire logic [3:0] i_nbits,
  output logic o_rxd
);
  logic [11:0] got_q[$];
  initial o_rxd = 1'b1;
  initial forever
  begin : rx
    logic [11:0] f;
    f = '0;
    @(negedge i_txd);
    repeat (DIV / 2) @(posedge i_clock);
    for (int i = 0; i < i_nbits; i++)
    begin
      repeat (DIV) @(posedge i_clock);
      f[i] = i_txd;
    end
    got_q.push_back(f);
  end
  // Bits go out LSB first after a low start bit, then the line idles high
  task automatic send(input logic [11:0] f, input int n);
    o_rxd <= 1'b0;
    repeat (DIV) @(posedge i_clock);
    for (int i = 0; i < n; i++)
    begin
      o_rxd <= f[i];
      repeat (DIV) @(posedge i_clock);
    end
    o_rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### bench/test_cup_port.sv
/* Testbench of the serial port: frame table, then buffer, error, modem cases.
   Assumes cup_dev on the data lines and APB with zero wait states or more. */
`timescale 1ns/1ns
`default_nettype none
module test_cup_port;
  localparam int DIV = 8;
  logic clock, rstn, psel, penable, pwrite, reinit, suspend, rxd, txd, err;
  logic cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n, cts_pu, dsr_pu, irq, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] nbits;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  typedef struct {logic [14:0] cfg; logic [7:0] data; logic [11:0] frame; int n; logic [7:0] back;} cup_row_s;
  cup_row_s rows[7] = '{'{15'h4003, 8'hA5, 12'h1A5, 9, 8'hA5}, '{15'h4013, 8'hA5, 12'h3A5, 10, 8'hA5},
    '{15'h4023, 8'h07, 12'h307, 10, 8'h07}, '{15'h4033, 8'h00, 12'h300, 10, 8'h00},
    '{15'h4043, 8'hFF, 12'h2FF, 10, 8'hFF}, '{15'h402F, 8'h55, 12'h355, 10, 8'h55},
    '{15'h4017, 8'h81, 12'h101, 9, 8'h01}};
  cup_port u_dut (.i_clock(clock), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_reinit(reinit), .i_suspend(suspend), .i_rxd(rxd), .o_txd(txd), .o_rts_n(rts_n), .i_cts_n(cts_n),
    .o_dtr_n(dtr_n), .i_dsr_n(dsr_n), .i_ri_n(ri_n), .i_dcd_n(dcd_n), .o_cts_pullup_en(cts_pu),
    .o_dsr_pullup_en(dsr_pu), .o_irq(irq));
  cup_dev #(.DIV(DIV)) u_dev (.i_clock(clock), .i_txd(txd), .i_nbits(nbits), .o_rxd(rxd));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Frames are short, so the whole run fits well below this ceiling
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic setup(input logic [31:0] cfg);
    apb(1'b1, cup_pkg::ADDR_CFG_STORE, cfg);
    reinit <= 1'b1;
    @(posedge clock);
    reinit <= 1'b0;
    @(posedge clock);
  endtask
  initial
  begin
    {rstn, psel, penable, pwrite, reinit, suspend, ri_n, dcd_n, cts_n, dsr_n} = 10'h00C;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    nbits = 4'h9;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rc("cfg reset", cup_pkg::ADDR_CFG_ACTIVE, 32'h0000_4003);
    apb(1'b1, cup_pkg::ADDR_DIV_STORE, DIV);
    rc("div held", cup_pkg::ADDR_DIV_ACTIVE, 32'h0000_01B2);
    foreach (rows[i])
    begin
      nbits <= 4'(rows[i].n);
      setup(32'(rows[i].cfg));
      apb(1'b1, cup_pkg::ADDR_DATA, 32'(rows[i].data));
      wait (u_dev.got_q.size() > 0);
      chk("tx frame", 32'(rows[i].frame), 32'(u_dev.got_q.pop_front()));
      @(posedge clock);
      u_dev.send(rows[i].frame, rows[i].n);
      rc("rx byte", cup_pkg::ADDR_DATA, 32'(rows[i].back));
      $display("row %0d done", i);
    end
    nbits <= 4'h9;
    setup(32'h0000_4003);
    apb(1'b1, cup_pkg::ADDR_DATA, 32'h0000_0011);
    apb(1'b1, cup_pkg::ADDR_DATA, 32'h0000_0022);
    wait (u_dev.got_q.size() == 2);
    chk("back to back", 32'h0000_0111, 32'(u_dev.got_q.pop_front()));
    chk("back to back", 32'h0000_0122, 32'(u_dev.got_q.pop_front()));
    @(posedge clock);
    cts_n <= 1'b1;
    for (int k = 0; k < 256; k++)
      apb(1'b1, cup_pkg::ADDR_DATA, 32'(k));
    apb(1'b0, cup_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("tx full", 32'h0000_0001, {31'h0, rd[0]});
    apb(1'b1, cup_pkg::ADDR_DATA, 32'h0000_00AA);
    chk("full refused", 32'h0000_0001, {31'h0, err});
    cts_n <= 1'b0;
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    $display("buffer test done");
    setup(32'h0000_6023);
    apb(1'b1, cup_pkg::ADDR_INT_STAT, 32'h0000_003F);
    u_dev.send(12'h207, 10);
    apb(1'b0, cup_pkg::ADDR_INT_STAT, 32'h0000_0000);
    chk("parity flag", 32'h0000_0002, {rd[2], rd[0]});
    setup(32'h0000_4003);
    apb(1'b1, cup_pkg::ADDR_INT_MASK, 32'h0000_0000);
    u_dev.send(12'h05A, 9);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, cup_pkg::ADDR_INT_MASK, 32'h0000_0008);
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    rc("framing kept", cup_pkg::ADDR_DATA, 32'h0000_025A);
    apb(1'b1, cup_pkg::ADDR_INT_STAT, 32'h0000_0008);
    chk("irq clear", 32'h0000_0000, {31'h0, irq});
    $display("error test done");
    ri_n <= 1'b0;
    for (int t = 0; t < 4; t++)
    begin
      setup(32'h0000_4000 | t);
      apb(1'b1, cup_pkg::ADDR_CTRL, 32'h0000_0003);
      chk("rts dtr", 32'((t == 0) ? 3 : ((t == 1) ? 1 : 0)), {30'h0, rts_n, dtr_n});
      apb(1'b0, cup_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("ri sensed", 32'(t == 3), {31'h0, rd[7]});
    end
    setup(32'h0000_5F83);
    apb(1'b1, cup_pkg::ADDR_CTRL, 32'h0000_0003);
    chk("inverted outs", 32'h0000_0003, {rts_n, dtr_n});
    apb(1'b0, cup_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("inverted ins", 32'h0000_0004, {28'h000_0000, rd[7:4]});
    suspend <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    chk("pullups off", 32'h0000_0000, {cts_pu, dsr_pu});
    setup(32'h0000_0003);
    chk("pullups kept", 32'h0000_0003, {cts_pu, dsr_pu});
    $display("modem test done");
    end_sim();
  end
endmodule
`default_nettype wire
